// [core/rtb_pkg.sv]
// constants, register map and timing for the rf timer and irq mask bank
// Behaviour
// - peer wait count, 64 carrier periods a step, is the longest peer wait
// - squelch count above 5 and below mask receive count: squelch on 20 us after tx end, off after count
// - at squelch end the squelch gain reduction is locked as agc start gain
// - count <= 5 or >= mask receive count: squelch until mask timer expires
// - squelch count uses mask receive step size and range, incl. step bit
// - field-on guard is 75 us plus guard count times 2048 carrier periods
// - main mask bits 7..1 suppress their interrupts; bit 0 unused
// - timer/nfc mask bits 7..0 suppress their eight interrupts
// - error/wake-up mask bits 7..0 suppress their eight interrupts
// - passive target mask bits suppress their interrupts; bit 2 reserved
// - an interrupt status register clears to zero after software reads it
// - mask receive step bit: 0 means 64 carrier periods, 1 means 512
package rtb_pkg;
   // register index = printed offset; byte address = 4 * index
   localparam logic [5:0] IDX_SQUELCH    = 6'h0F; // space b
   localparam logic [5:0] IDX_PEER_WAIT  = 6'h15; // space a
   localparam logic [5:0] IDX_GUARD      = 6'h15; // space b
   localparam logic [5:0] IDX_MASK_MAIN  = 6'h16;
   localparam logic [5:0] IDX_MASK_TNFC  = 6'h17;
   localparam logic [5:0] IDX_MASK_ERR   = 6'h18;
   localparam logic [5:0] IDX_MASK_PT    = 6'h19;
   localparam logic [5:0] IDX_STAT_MAIN  = 6'h1A;
   localparam logic [5:0] IDX_STAT_TNFC  = 6'h1B;
   localparam logic [5:0] IDX_STAT_ERR   = 6'h1C;
   localparam logic [5:0] IDX_STAT_PT    = 6'h1D;
   localparam logic [5:0] IDX_MRT_CTRL   = 6'h12; // bit 3 = step select
   localparam logic [5:0] IDX_MRT_COUNT  = 6'h0E; // space b chosen index
   localparam int         SPACE_BIT      = 8;     // adr bit 8 selects space b
   localparam int         MRT_STEP_BIT   = 3;

   localparam logic [7:0] RST_PEER_WAIT  = 8'h80;
   localparam logic [7:0] RST_GUARD      = 8'h33;
   localparam logic [7:0] RST_ZERO       = 8'h00;
   localparam logic [7:0] MAIN_USED      = 8'hFE;
   localparam logic [7:0] PT_USED        = 8'hFB;
   localparam logic [7:0] SQ_MIN_COUNT   = 8'h05;

   // carrier periods per step
   localparam int FC_PEER_STEP   = 64;
   localparam int FC_MRT_STEP0   = 64;
   localparam int FC_MRT_STEP1   = 512;
   localparam int FC_GUARD_STEP  = 2048;
   localparam int FC_HZ          = 13_560_000;
   localparam int CLK_HZ         = 50_000_000;
   localparam int SQ_DELAY_NS    = 20_000;
   localparam int GUARD_BASE_NS  = 75_000;

   function automatic int fc_to_clk(input int fc_periods);
      fc_to_clk = int'((longint'(fc_periods) * CLK_HZ + FC_HZ - 1) / FC_HZ);
   endfunction

   localparam int CYC_PEER_STEP  = fc_to_clk(FC_PEER_STEP);
   localparam int CYC_MRT_STEP0  = fc_to_clk(FC_MRT_STEP0);
   localparam int CYC_MRT_STEP1  = fc_to_clk(FC_MRT_STEP1);
   localparam int CYC_GUARD_STEP = fc_to_clk(FC_GUARD_STEP);
   localparam int CYC_SQ_DELAY   = SQ_DELAY_NS / (1_000_000_000 / CLK_HZ);
   localparam int CYC_GUARD_BASE = GUARD_BASE_NS / (1_000_000_000 / CLK_HZ);

   typedef enum logic [3:0] {
      RTB_SQ_IDLE  = 4'b0001,
      RTB_SQ_DELAY = 4'b0010,
      RTB_SQ_ON    = 4'b0100,
      RTB_SQ_HOLD  = 4'b1000
   } rtb_sq_e;
endpackage

// [core/rtb_step_timer.sv]
// step timer: counts a number of steps of a given length, pulses when done
`timescale 1ns/10ps
module rtb_step_timer #(
   parameter int CW = 16
) (
   input  wire logic          core_clk,
   input  wire logic          reset,
   input  wire logic          start,
   input  wire logic [CW-1:0] step_cycles,
   input  wire logic [8:0]    steps,
   output logic               busy,
   output logic               done
);
   logic [CW-1:0] pre_r, pre_nxt;
   logic [8:0]    cnt_r, cnt_nxt;
   logic          busy_r, busy_nxt, done_r, done_nxt;

   always_comb begin
      pre_nxt  = pre_r;
      cnt_nxt  = cnt_r;
      busy_nxt = busy_r;
      done_nxt = 1'b0;
      if (start) begin
         pre_nxt  = step_cycles;
         cnt_nxt  = steps;
         busy_nxt = 1'b1;
      end else if (busy_r) begin
         if (cnt_r == 9'h000) begin
            busy_nxt = 1'b0;
            done_nxt = 1'b1;
         end else if (pre_r <= CW'(1)) begin
            pre_nxt = step_cycles;
            cnt_nxt = cnt_r - 9'h001;
         end else begin
            pre_nxt = pre_r - CW'(1);
         end
      end
   end

   always_ff @(posedge core_clk) begin
      if (reset) begin
         pre_r  <= '0;
         cnt_r  <= 9'h000;
         busy_r <= 1'b0;
         done_r <= 1'b0;
      end else begin
         pre_r  <= pre_nxt;
         cnt_r  <= cnt_nxt;
         busy_r <= busy_nxt;
         done_r <= done_nxt;
      end
   end

   assign busy = busy_r;
   assign done = done_r;
endmodule

// [core/rtb_bank.sv]
// rf timer register bank, interrupt masks/status, squelch and guard timing
`timescale 1ns/10ps
module rtb_bank (
   input  wire logic        core_clk,
   input  wire logic        reset,
   input  wire logic        wb_cyc_i,
   input  wire logic        wb_stb_i,
   input  wire logic        wb_we_i,
   input  wire logic [10:0] wb_adr_i,
   input  wire logic [3:0]  wb_sel_i,
   input  wire logic [31:0] wb_dat_i,
   output logic      [31:0] wb_dat_o,
   output logic             wb_ack_o,
   input  wire logic [7:0]  ev_main,
   input  wire logic [7:0]  ev_timer_nfc,
   input  wire logic [7:0]  ev_error_wakeup,
   input  wire logic [7:0]  ev_passive_target,
   output logic             irq,
   input  wire logic        tx_end,
   input  wire logic        peer_wait_start,
   input  wire logic        peer_field_on,
   output logic             peer_wait_expired,
   input  wire logic        field_on_cmd,
   output logic             field_guard_done,
   input  wire logic [7:0]  gain_reduction,
   output logic             squelch_on,
   output logic      [7:0]  agc_start_gain
);
   ////////////////////////////////////////////////////////////////////////
   // registers
   logic [7:0] squelch_time_r, squelch_time_nxt;
   logic [7:0] peer_field_wait_time_r, peer_field_wait_time_nxt;
   logic [7:0] field_on_guard_time_r, field_on_guard_time_nxt;
   logic [7:0] main_irq_mask_r, main_irq_mask_nxt;
   logic [7:0] timer_nfc_irq_mask_r, timer_nfc_irq_mask_nxt;
   logic [7:0] error_wakeup_irq_mask_r, error_wakeup_irq_mask_nxt;
   logic [7:0] passive_target_irq_mask_r, passive_target_irq_mask_nxt;
   logic [7:0] mrt_ctrl_r, mrt_ctrl_nxt;
   logic [7:0] mrt_count_r, mrt_count_nxt;
   logic [7:0] st_main_r, st_main_nxt, st_tnfc_r, st_tnfc_nxt;
   logic [7:0] st_err_r, st_err_nxt, st_pt_r, st_pt_nxt;
   logic [31:0] dat_r, dat_nxt;
   logic        ack_r, ack_nxt;

   logic       req, wr, rd, space_b, bad_hi;
   logic [5:0] idx;
   assign req     = wb_cyc_i && wb_stb_i && !ack_r;
   assign wr      = req && wb_we_i && wb_sel_i[0];
   assign rd      = req && !wb_we_i;
   assign space_b = wb_adr_i[rtb_pkg::SPACE_BIT];
   assign idx     = wb_adr_i[7:2];
   assign bad_hi  = wb_adr_i[10:9] != 2'b00;

   function automatic logic hit(input logic b, input logic [5:0] i);
      hit = !bad_hi && (space_b == b) && (idx == i);
   endfunction

   always_comb begin
      squelch_time_nxt            = squelch_time_r;
      peer_field_wait_time_nxt    = peer_field_wait_time_r;
      field_on_guard_time_nxt     = field_on_guard_time_r;
      main_irq_mask_nxt           = main_irq_mask_r;
      timer_nfc_irq_mask_nxt      = timer_nfc_irq_mask_r;
      error_wakeup_irq_mask_nxt   = error_wakeup_irq_mask_r;
      passive_target_irq_mask_nxt = passive_target_irq_mask_r;
      mrt_ctrl_nxt                = mrt_ctrl_r;
      mrt_count_nxt               = mrt_count_r;
      ack_nxt                     = req;
      dat_nxt                     = 32'h0000_0000;
      if (wr) begin
         if (hit(1'b1, rtb_pkg::IDX_SQUELCH))
            squelch_time_nxt = wb_dat_i[7:0];
         if (hit(1'b0, rtb_pkg::IDX_PEER_WAIT))
            peer_field_wait_time_nxt = wb_dat_i[7:0];
         if (hit(1'b1, rtb_pkg::IDX_GUARD))
            field_on_guard_time_nxt = wb_dat_i[7:0];
         if (hit(1'b0, rtb_pkg::IDX_MASK_MAIN))
            main_irq_mask_nxt = wb_dat_i[7:0] & rtb_pkg::MAIN_USED;
         if (hit(1'b0, rtb_pkg::IDX_MASK_TNFC))
            timer_nfc_irq_mask_nxt = wb_dat_i[7:0];
         if (hit(1'b0, rtb_pkg::IDX_MASK_ERR))
            error_wakeup_irq_mask_nxt = wb_dat_i[7:0];
         if (hit(1'b0, rtb_pkg::IDX_MASK_PT))
            passive_target_irq_mask_nxt = wb_dat_i[7:0]
                                        & rtb_pkg::PT_USED;
         if (hit(1'b0, rtb_pkg::IDX_MRT_CTRL))
            mrt_ctrl_nxt = wb_dat_i[7:0];
         if (hit(1'b1, rtb_pkg::IDX_MRT_COUNT))
            mrt_count_nxt = wb_dat_i[7:0];
      end
      if (rd) begin
         if (hit(1'b1, rtb_pkg::IDX_SQUELCH))
            dat_nxt[7:0] = squelch_time_r;
         if (hit(1'b0, rtb_pkg::IDX_PEER_WAIT))
            dat_nxt[7:0] = peer_field_wait_time_r;
         if (hit(1'b1, rtb_pkg::IDX_GUARD))
            dat_nxt[7:0] = field_on_guard_time_r;
         if (hit(1'b0, rtb_pkg::IDX_MASK_MAIN))
            dat_nxt[7:0] = main_irq_mask_r;
         if (hit(1'b0, rtb_pkg::IDX_MASK_TNFC))
            dat_nxt[7:0] = timer_nfc_irq_mask_r;
         if (hit(1'b0, rtb_pkg::IDX_MASK_ERR))
            dat_nxt[7:0] = error_wakeup_irq_mask_r;
         if (hit(1'b0, rtb_pkg::IDX_MASK_PT))
            dat_nxt[7:0] = passive_target_irq_mask_r;
         if (hit(1'b0, rtb_pkg::IDX_MRT_CTRL))
            dat_nxt[7:0] = mrt_ctrl_r;
         if (hit(1'b1, rtb_pkg::IDX_MRT_COUNT))
            dat_nxt[7:0] = mrt_count_r;
         if (hit(1'b0, rtb_pkg::IDX_STAT_MAIN))
            dat_nxt[7:0] = st_main_r;
         if (hit(1'b0, rtb_pkg::IDX_STAT_TNFC))
            dat_nxt[7:0] = st_tnfc_r;
         if (hit(1'b0, rtb_pkg::IDX_STAT_ERR))
            dat_nxt[7:0] = st_err_r;
         if (hit(1'b0, rtb_pkg::IDX_STAT_PT))
            dat_nxt[7:0] = st_pt_r;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // interrupt status: read clears, a same-cycle event survives the clear
   function automatic logic [7:0] sticky(input logic [7:0] cur,
                                         input logic [7:0] ev,
                                         input logic       clr);
      sticky = (clr ? 8'h00 : cur) | ev;
   endfunction

   always_comb begin
      st_main_nxt = sticky(st_main_r, ev_main & rtb_pkg::MAIN_USED,
                           rd && hit(1'b0, rtb_pkg::IDX_STAT_MAIN));
      st_tnfc_nxt = sticky(st_tnfc_r, ev_timer_nfc,
                           rd && hit(1'b0, rtb_pkg::IDX_STAT_TNFC));
      st_err_nxt  = sticky(st_err_r, ev_error_wakeup,
                           rd && hit(1'b0, rtb_pkg::IDX_STAT_ERR));
      st_pt_nxt   = sticky(st_pt_r, ev_passive_target & rtb_pkg::PT_USED,
                           rd && hit(1'b0, rtb_pkg::IDX_STAT_PT));
   end

   // a 1 in a mask suppresses the request only
   assign irq = |(st_main_r & ~main_irq_mask_r)
              | |(st_tnfc_r & ~timer_nfc_irq_mask_r)
              | |(st_err_r & ~error_wakeup_irq_mask_r)
              | |(st_pt_r & ~passive_target_irq_mask_r);

   always_ff @(posedge core_clk) begin
      if (reset) begin
         squelch_time_r            <= rtb_pkg::RST_ZERO;
         peer_field_wait_time_r    <= rtb_pkg::RST_PEER_WAIT;
         field_on_guard_time_r     <= rtb_pkg::RST_GUARD;
         main_irq_mask_r           <= rtb_pkg::RST_ZERO;
         timer_nfc_irq_mask_r      <= rtb_pkg::RST_ZERO;
         error_wakeup_irq_mask_r   <= rtb_pkg::RST_ZERO;
         passive_target_irq_mask_r <= rtb_pkg::RST_ZERO;
         mrt_ctrl_r                <= rtb_pkg::RST_ZERO;
         mrt_count_r               <= rtb_pkg::RST_ZERO;
         st_main_r                 <= rtb_pkg::RST_ZERO;
         st_tnfc_r                 <= rtb_pkg::RST_ZERO;
         st_err_r                  <= rtb_pkg::RST_ZERO;
         st_pt_r                   <= rtb_pkg::RST_ZERO;
         dat_r                     <= 32'h0000_0000;
         ack_r                     <= 1'b0;
      end else begin
         squelch_time_r            <= squelch_time_nxt;
         peer_field_wait_time_r    <= peer_field_wait_time_nxt;
         field_on_guard_time_r     <= field_on_guard_time_nxt;
         main_irq_mask_r           <= main_irq_mask_nxt;
         timer_nfc_irq_mask_r      <= timer_nfc_irq_mask_nxt;
         error_wakeup_irq_mask_r   <= error_wakeup_irq_mask_nxt;
         passive_target_irq_mask_r <= passive_target_irq_mask_nxt;
         mrt_ctrl_r                <= mrt_ctrl_nxt;
         mrt_count_r               <= mrt_count_nxt;
         st_main_r                 <= st_main_nxt;
         st_tnfc_r                 <= st_tnfc_nxt;
         st_err_r                  <= st_err_nxt;
         st_pt_r                   <= st_pt_nxt;
         dat_r                     <= dat_nxt;
         ack_r                     <= ack_nxt;
      end
   end

   assign wb_dat_o = dat_r;
   assign wb_ack_o = ack_r;

   ////////////////////////////////////////////////////////////////////////
   // timers
   localparam int CW = 16;
   logic [CW-1:0] mrt_step_cyc;
   logic          peer_busy, guard_base_done, sq_done, mrt_done;
   logic          sq_start, mrt_start;

   // squelch and mask receive share one step length
   assign mrt_step_cyc = mrt_ctrl_r[rtb_pkg::MRT_STEP_BIT]
                       ? CW'(rtb_pkg::CYC_MRT_STEP1)
                       : CW'(rtb_pkg::CYC_MRT_STEP0);

   // peer wait: expiry always reported; the peer field is left to the caller
   rtb_step_timer #(.CW(CW)) u_peer (
      .core_clk    (core_clk),
      .reset       (reset),
      .start       (peer_wait_start),
      .step_cycles (CW'(rtb_pkg::CYC_PEER_STEP)),
      .steps       ({1'b0, peer_field_wait_time_r}),
      .busy        (peer_busy),
      .done        (peer_wait_expired)
   );

   // guard: base interval counted as one step, then count steps
   rtb_step_timer #(.CW(CW)) u_guard_base (
      .core_clk    (core_clk),
      .reset       (reset),
      .start       (field_on_cmd),
      .step_cycles (CW'(rtb_pkg::CYC_GUARD_BASE)),
      .steps       (9'h001),
      .busy        (),
      .done        (guard_base_done)
   );
   rtb_step_timer #(.CW(CW)) u_guard (
      .core_clk    (core_clk),
      .reset       (reset),
      .start       (guard_base_done),
      .step_cycles (CW'(rtb_pkg::CYC_GUARD_STEP)),
      .steps       ({1'b0, field_on_guard_time_r}),
      .busy        (),
      .done        (field_guard_done)
   );

   // mask receive timer runs from tx end; squelch shares its steps
   assign mrt_start = tx_end;
   rtb_step_timer #(.CW(CW)) u_mrt (
      .core_clk    (core_clk),
      .reset       (reset),
      .start       (mrt_start),
      .step_cycles (mrt_step_cyc),
      .steps       ({1'b0, mrt_count_r}),
      .busy        (),
      .done        (mrt_done)
   );
   rtb_step_timer #(.CW(CW)) u_sq (
      .core_clk    (core_clk),
      .reset       (reset),
      .start       (sq_start),
      .step_cycles (mrt_step_cyc),
      .steps       ({1'b0, squelch_time_r}),
      .busy        (),
      .done        (sq_done)
   );

   ////////////////////////////////////////////////////////////////////////
   // squelch sequencer
   rtb_pkg::rtb_sq_e sq_r, sq_nxt;
   logic [CW-1:0]    dly_r, dly_nxt;
   logic [7:0]       gain_r, gain_nxt;
   logic             short_mode;

   // short or too long counts fall back to the mask receive timer
   assign short_mode = (squelch_time_r <= rtb_pkg::SQ_MIN_COUNT)
                    || (squelch_time_r >= mrt_count_r);

   always_comb begin
      sq_nxt   = sq_r;
      dly_nxt  = dly_r;
      gain_nxt = gain_r;
      sq_start = 1'b0;
      unique case (sq_r)
         rtb_pkg::RTB_SQ_IDLE: begin
            if (tx_end) begin
               if (short_mode)
                  sq_nxt = rtb_pkg::RTB_SQ_HOLD;
               else begin
                  sq_nxt  = rtb_pkg::RTB_SQ_DELAY;
                  dly_nxt = CW'(rtb_pkg::CYC_SQ_DELAY);
               end
            end
         end
         rtb_pkg::RTB_SQ_DELAY: begin
            if (dly_r <= CW'(1)) begin
               sq_nxt   = rtb_pkg::RTB_SQ_ON;
               sq_start = 1'b1;
            end else
               dly_nxt = dly_r - CW'(1);
         end
         rtb_pkg::RTB_SQ_ON: begin
            if (sq_done) begin
               sq_nxt   = rtb_pkg::RTB_SQ_IDLE;
               gain_nxt = gain_reduction;
            end
         end
         rtb_pkg::RTB_SQ_HOLD: begin
            if (mrt_done) begin
               sq_nxt   = rtb_pkg::RTB_SQ_IDLE;
               gain_nxt = gain_reduction;
            end
         end
      endcase
   end

   always_ff @(posedge core_clk) begin
      if (reset) begin
         sq_r   <= rtb_pkg::RTB_SQ_IDLE;
         dly_r  <= '0;
         gain_r <= rtb_pkg::RST_ZERO;
      end else begin
         sq_r   <= sq_nxt;
         dly_r  <= dly_nxt;
         gain_r <= gain_nxt;
      end
   end

   assign squelch_on = (sq_r == rtb_pkg::RTB_SQ_ON)
                    || (sq_r == rtb_pkg::RTB_SQ_HOLD);
   assign agc_start_gain = gain_r;
endmodule

// [tb/rtb_bank_checker.sv]
// concurrent checks on the ports of the rf timer and irq mask bank
`timescale 1ns/10ps
module rtb_bank_checker (
   input wire logic        core_clk,
   input wire logic        reset,
   input wire logic        wb_cyc_i,
   input wire logic        wb_stb_i,
   input wire logic        wb_we_i,
   input wire logic [31:0] wb_dat_o,
   input wire logic        wb_ack_o,
   input wire logic        irq,
   input wire logic        field_on_cmd,
   input wire logic        field_guard_done,
   input wire logic        peer_wait_expired,
   input wire logic        squelch_on,
   input wire logic [7:0]  agc_start_gain
);
   // a guard count of zero still leaves the fixed base interval
   localparam int GUARD_MIN = rtb_pkg::CYC_GUARD_BASE - 8;
   logic [15:0] since_cmd_r;
   logic [15:0] since_cmd_nxt;
   ////////////////////////////////////////////////////////////////////////
   always_comb begin
      since_cmd_nxt = since_cmd_r;
      if (field_on_cmd)
         since_cmd_nxt = 16'h0000;
      else if (since_cmd_r != 16'hFFFF)
         since_cmd_nxt = since_cmd_r + 16'h0001;
   end
   always_ff @(posedge core_clk)
      if (reset)
         since_cmd_r <= 16'hFFFF;
      else
         since_cmd_r <= since_cmd_nxt;
   ////////////////////////////////////////////////////////////////////////
   default clocking @(posedge core_clk);
   endclocking
   default disable iff (reset);
   a_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
      else $error("ack held longer than one cycle");
   a_ack_cause: assert property (wb_ack_o |-> $past(wb_stb_i))
      else $error("ack without a request");
   a_req_answer: assert property
      ((wb_cyc_i && wb_stb_i && !wb_ack_o) |=> wb_ack_o)
      else $error("request not answered in one cycle");
   a_rdata_upper: assert property (wb_ack_o |-> wb_dat_o[31:8] == 24'h000000)
      else $error("read data upper bits not zero");
   a_guard_base: assert property
      (field_guard_done |-> since_cmd_r >= GUARD_MIN)
      else $error("guard finished before base interval");
   a_guard_pulse: assert property
      (field_guard_done |=> !field_guard_done)
      else $error("guard done longer than one cycle");
   a_peer_pulse: assert property
      (peer_wait_expired |=> !peer_wait_expired)
      else $error("peer wait expiry longer than one cycle");
   a_agc_lock: assert property
      ($changed(agc_start_gain) |-> $past(squelch_on) || $past(squelch_on, 2))
      else $error("agc start gain moved outside squelch end");
   a_quiet_reset: assert property
      ($past(reset) |-> !irq && !squelch_on && !wb_ack_o)
      else $error("outputs active right after reset");
   c_read: cover property (wb_ack_o && !wb_we_i);
   c_sq_end: cover property ($fell(squelch_on));
   c_irq_clear: cover property (irq ##1 !irq);
endmodule
bind rtb_bank rtb_bank_checker i_checker (
   .core_clk(core_clk), .reset(reset), .wb_cyc_i(wb_cyc_i),
   .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_dat_o(wb_dat_o),
   .wb_ack_o(wb_ack_o), .irq(irq), .field_on_cmd(field_on_cmd),
   .field_guard_done(field_guard_done),
   .peer_wait_expired(peer_wait_expired), .squelch_on(squelch_on),
   .agc_start_gain(agc_start_gain));

// [tb/rtb_bank_tb.sv]
// self-checking bench for the rf timer and irq mask bank
`timescale 1ns/10ps
module rtb_bank_tb;
   localparam logic [5:0] IX [7] = '{rtb_pkg::IDX_SQUELCH,
      rtb_pkg::IDX_PEER_WAIT, rtb_pkg::IDX_GUARD, rtb_pkg::IDX_MASK_MAIN,
      rtb_pkg::IDX_MASK_TNFC, rtb_pkg::IDX_MASK_ERR, rtb_pkg::IDX_MASK_PT};
   localparam logic [6:0] SP = 7'b0000101;
   localparam logic [7:0] RV [7] = '{8'h00, 8'h80, 8'h33, 8'h00, 8'h00,
      8'h00, 8'h00};
   localparam logic [7:0] UM [7] = '{8'hFF, 8'hFF, 8'hFF, 8'hFE, 8'hFF,
      8'hFF, 8'hFB};
   logic        core_clk;
   logic        reset;
   logic        wb_cyc_i;
   logic        wb_stb_i;
   logic        wb_we_i;
   logic [10:0] wb_adr_i;
   logic [31:0] wb_dat_i;
   logic [31:0] wb_dat_o;
   logic        wb_ack_o;
   logic [7:0]  ev_r [4];
   logic        irq;
   logic        tx_end;
   logic        peer_wait_start;
   logic        peer_wait_expired;
   logic        field_on_cmd;
   logic        field_guard_done;
   logic [7:0]  gain_reduction;
   logic        squelch_on;
   logic [7:0]  agc_start_gain;
   logic [7:0]  rnd;
   logic [31:0] exp_q [$];
   int          fails;
   int          total_checks;
   int          cyc_n;
   int          n;
   ////////////////////////////////////////////////////////////////////////
   rtb_bank i_dut (.core_clk(core_clk), .reset(reset), .wb_cyc_i(wb_cyc_i),
      .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
      .wb_sel_i(4'hF), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
      .wb_ack_o(wb_ack_o), .ev_main(ev_r[0]), .ev_timer_nfc(ev_r[1]),
      .ev_error_wakeup(ev_r[2]), .ev_passive_target(ev_r[3]), .irq(irq),
      .tx_end(tx_end), .peer_wait_start(peer_wait_start),
      .peer_field_on(1'b0), .peer_wait_expired(peer_wait_expired),
      .field_on_cmd(field_on_cmd), .field_guard_done(field_guard_done),
      .gain_reduction(gain_reduction), .squelch_on(squelch_on),
      .agc_start_gain(agc_start_gain));
   initial begin
      core_clk = 1'b0;
      forever #10 core_clk = ~core_clk;
   end
   ////////////////////////////////////////////////////////////////////////
   function automatic logic [7:0] lfsr(input logic [7:0] s);
      lfsr = {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
   endfunction
   function automatic logic [10:0] ra(input logic sp, input logic [5:0] ix);
      ra = {2'b00, sp, ix, 2'b00};
   endfunction
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      total_checks++;
      if (got !== exp) begin
         fails++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic near(input int got, input int e);
      chk(32'((got >= e - 2) && (got <= e + 10)), 32'h1);
   endtask
   task automatic results();
      $display("checks %0d fails %0d", total_checks, fails);
      if (fails == 0 && total_checks > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask
   // one classic cycle; waits for ack, then one idle cycle before the next
   task automatic wb(input logic we, input logic [10:0] a,
                     input logic [7:0] d);
      @(posedge core_clk);
      wb_cyc_i <= 1'b1;
      wb_stb_i <= 1'b1;
      wb_we_i <= we;
      wb_adr_i <= a;
      wb_dat_i <= {24'h000000, d};
      // no local limit: a missing ack runs into the cycle ceiling
      do begin
         @(posedge core_clk);
      end while (wb_ack_o !== 1'b1);
      wb_cyc_i <= 1'b0;
      wb_stb_i <= 1'b0;
      wb_we_i <= 1'b0;
      @(posedge core_clk);
   endtask
   task automatic rd(input logic [10:0] a, input logic [31:0] e);
      exp_q.push_back(e);
      wb(1'b0, a, 8'h00);
   endtask
   task automatic kick(input int k);
      @(posedge core_clk);
      tx_end <= (k == 0);
      peer_wait_start <= (k == 1);
      field_on_cmd <= (k == 2);
      @(posedge core_clk);
      tx_end <= 1'b0;
      peer_wait_start <= 1'b0;
      field_on_cmd <= 1'b0;
   endtask
   task automatic evp(input int g, input logic [7:0] v);
      @(posedge core_clk);
      ev_r[g] <= v;
      @(posedge core_clk);
      ev_r[g] <= 8'h00;
      @(posedge core_clk);
      #1;
   endtask
   task automatic wait_lvl(input int k, input logic lvl, output int c);
      logic s;
      c = 0;
      do begin
         @(posedge core_clk);
         c++;
         s = (k == 0) ? squelch_on : (k == 1) ? field_guard_done
                                               : peer_wait_expired;
      end while (s !== lvl && c < 40000);
   endtask
   task automatic sq_case(input logic [7:0] sq, input logic st);
      int n0;
      int n1;
      int stp;
      logic [7:0] g;
      stp = st ? rtb_pkg::CYC_MRT_STEP1 : rtb_pkg::CYC_MRT_STEP0;
      wb(1'b1, ra(1'b0, rtb_pkg::IDX_MRT_CTRL), {4'h0, st, 3'h0});
      wb(1'b1, ra(1'b1, rtb_pkg::IDX_SQUELCH), sq);
      rnd = lfsr(rnd);
      g = rnd;
      gain_reduction <= g;
      kick(0);
      wait_lvl(0, 1'b1, n0);
      wait_lvl(0, 1'b0, n1);
      if (sq > 8'h05 && sq < 8'h14) begin
         near(n0, rtb_pkg::CYC_SQ_DELAY);
         near(n1, int'(sq) * stp);
      end else begin
         near(n0 + n1, 20 * stp);
      end
      @(posedge core_clk);
      #1;
      chk({24'h000000, agc_start_gain}, {24'h000000, g});
      // let the mask receive timer run out so cases stay independent
      if (n0 + n1 < 20 * stp)
         repeat (20 * stp - n0 - n1 + 4) @(posedge core_clk);
   endtask
   ////////////////////////////////////////////////////////////////////////
   always @(posedge core_clk)
      if (wb_ack_o === 1'b1 && wb_we_i === 1'b0) begin
         if (exp_q.size() > 0)
            chk(wb_dat_o, exp_q.pop_front());
         else
            chk(wb_dat_o, 32'hFFFFFFFF);
      end
   always @(posedge core_clk) begin
      cyc_n <= cyc_n + 1;
      if (cyc_n == 90000) begin
         fails++;
         results();
      end
   end
   initial begin
      reset = 1'b1;
      {wb_cyc_i, wb_stb_i, wb_we_i, tx_end} = 4'h0;
      {peer_wait_start, field_on_cmd} = 2'b00;
      wb_adr_i = 11'h000;
      wb_dat_i = 32'h00000000;
      ev_r = '{8'h00, 8'h00, 8'h00, 8'h00};
      gain_reduction = 8'h00;
      rnd = 8'h08;
      fails = 0;
      total_checks = 0;
      cyc_n = 0;
      repeat (8) @(posedge core_clk);
      reset <= 1'b0;
      for (int i = 0; i < 7; i++)
         rd(ra(SP[i], IX[i]), {24'h000000, RV[i]});
      for (int i = 0; i < 7; i++) begin
         rnd = lfsr(rnd);
         wb(1'b1, ra(SP[i], IX[i]), rnd);
         rd(ra(SP[i], IX[i]), {24'h000000, rnd & UM[i]});
      end
      wb(1'b1, ra(1'b1, 6'h3F), 8'hFF);
      rd(ra(1'b1, 6'h3F), 32'h00000000);
      $display("test registers done");
      for (int g = 0; g < 4; g++) begin
         wb(1'b1, ra(1'b0, IX[3+g]), 8'hFF);
         evp(g, 8'hFF);
         chk({31'h0, irq}, 32'h0);
         rd(ra(1'b0, rtb_pkg::IDX_STAT_MAIN + 6'(g)), {24'h0, UM[3+g]});
         rd(ra(1'b0, rtb_pkg::IDX_STAT_MAIN + 6'(g)), 32'h0);
         wb(1'b1, ra(1'b0, IX[3+g]), 8'h00);
         rnd = lfsr(rnd) | 8'h80;
         evp(g, rnd);
         chk({31'h0, irq}, 32'h1);
         rd(ra(1'b0, rtb_pkg::IDX_STAT_MAIN + 6'(g)),
            {24'h0, rnd & UM[3+g]});
         chk({31'h0, irq}, 32'h0);
      end
      $display("test interrupt masks done");
      wb(1'b1, ra(1'b0, rtb_pkg::IDX_PEER_WAIT), 8'h02);
      kick(1);
      wait_lvl(2, 1'b1, n);
      near(n, 2 * rtb_pkg::CYC_PEER_STEP);
      for (int c = 0; c < 2; c++) begin
         wb(1'b1, ra(1'b1, rtb_pkg::IDX_GUARD), 8'(c));
         kick(2);
         wait_lvl(1, 1'b1, n);
         near(n, rtb_pkg::CYC_GUARD_BASE
                 + c * rtb_pkg::CYC_GUARD_STEP);
      end
      $display("test timers done");
      wb(1'b1, ra(1'b1, rtb_pkg::IDX_MRT_COUNT), 8'h14);
      sq_case(8'h03, 1'b0);
      sq_case(8'h19, 1'b0);
      sq_case(8'h06, 1'b0);
      sq_case(8'h06, 1'b1);
      $display("test squelch done");
      results();
   end
endmodule
